// ==== design/meb_pkg.sv ====
// shared constants and types of the multiplexed external memory bus
// assumes one clk period equals one oscillator period
package meb_pkg;

    // machine cycle: 12 oscillator periods, index 0 = state1_phase1
    localparam logic [3:0] MEB_IDX_LAST = 4'hb;
    // one bus slot: 6 oscillator periods, two slots per machine cycle
    localparam logic [3:0] MEB_SLOT_LEN = 4'h6;

    // positions within a slot (0..5)
    localparam logic [2:0] MEB_POS_ALE_A = 3'h1;
    localparam logic [2:0] MEB_POS_ALE_B = 3'h2;
    localparam logic [2:0] MEB_POS_ADDR_END = 3'h3;
    localparam logic [2:0] MEB_POS_STB_LO = 3'h4;
    localparam logic [2:0] MEB_POS_DSTB_LO = 3'h5;
    localparam logic [2:0] MEB_POS_DSTB_END = 3'h4;

    // reset values
    localparam logic [3:0] MEB_IDX_RST = 4'h0;
    localparam logic [7:0] MEB_BYTE_RST = 8'h00;

    typedef enum logic [1:0] {
        MEB_ST_NORM,
        MEB_ST_MX1,
        MEB_ST_MX2
    } meb_state_t;

    // external data move command from the core
    typedef struct packed {
        logic write;
        logic wide;
        logic [15:0] addr;
        logic [7:0] wdata;
    } meb_xreq_t;

endpackage

// ==== design/meb_phase_gen.sv ====
// machine cycle phase counter of the external memory bus
// assumes clk is the oscillator; free running from reset
module meb_phase_gen
    import meb_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // phase position
    output logic [3:0] idx_ff,
    output logic [3:0] nxt_idx
);

    // fixed sequence, independent of where program memory sits
    assign nxt_idx = (idx_ff == MEB_IDX_LAST) ? MEB_IDX_RST : idx_ff + 4'h1;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idx_ff <= MEB_IDX_RST;
        end else begin
            idx_ff <= nxt_idx;
        end
    end

endmodule

// ==== design/meb_bus_ctrl.sv ====
// multiplexed external memory bus engine: fetch, data read/write
// assumes core signals are on clk; p0_i is an asynchronous pin
module meb_bus_ctrl
    import meb_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // program fetch from the core
    input wire logic ext_fetch_en,
    input wire logic [15:0] fetch_addr,
    output logic [7:0] fetch_data,
    output logic fetch_valid,
    // external data move from the core
    input wire logic xm_req,
    input meb_xreq_t xm_cmd,
    output logic xm_busy,
    output logic [7:0] xm_rdata,
    output logic xm_done,
    // port 2 latch content and cycle marker
    input wire logic [7:0] p2_latch,
    output logic mc_start,
    // bus pins
    output logic ale,
    output logic program_store_strobe_n,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] p0_o,
    output logic p0_oe,
    input wire logic [7:0] p0_i,
    output logic [7:0] p2_o
);

    function automatic logic [2:0] pos_of(input logic [3:0] i);
        pos_of = (i >= MEB_SLOT_LEN) ? 3'(i - MEB_SLOT_LEN) : i[2:0];
    endfunction

    logic [3:0] idx_ff;
    logic [3:0] nxt_idx;
    meb_state_t st_ff;
    meb_state_t nxt_st;
    logic pend_ff;
    meb_xreq_t xr_ff;
    logic dslot_ff;
    logic fslot_ff;
    logic program_store_strobe_n_d_ff;
    logic rd_d_ff;
    logic wr_d_ff;
    logic cap_f_ff;
    logic cap_r_ff;
    logic [7:0] p0_s1_ff;
    logic [7:0] p0_s2_ff;

    // machine cycle timing
    meb_phase_gen u_phase (
        .clk(clk),
        .rstn(rstn),
        .idx_ff(idx_ff),
        .nxt_idx(nxt_idx)
    );

    wire wrap = (idx_ff == MEB_IDX_LAST);
    wire accept = xm_req && !xm_busy;
    wire [2:0] pos = pos_of(nxt_idx);
    wire hi = (nxt_idx >= MEB_SLOT_LEN);
    wire addr_ph = (pos <= MEB_POS_ADDR_END);
    wire ale_pos = (pos == MEB_POS_ALE_A) || (pos == MEB_POS_ALE_B);
    wire first_d = (nxt_st == MEB_ST_MX1) && hi;
    wire second_d = (nxt_st == MEB_ST_MX2) && !hi;

    // data slot: second half of move cycle 1, first half of cycle 2
    wire nxt_dslot = first_d || second_d;
    // fetch slots give way to the data slot
    wire nxt_fslot = ext_fetch_en && !nxt_dslot;
    // latch strobe every slot but the first of move cycle 2
    wire nxt_ale = ale_pos && !second_d;
    // program store strobe low in positions 4,5
    wire nxt_program_store_strobe_n_n = !(nxt_fslot && pos >= MEB_POS_STB_LO);
    // data strobe window, 6 periods, same for memory and i/o
    wire dstb = first_d ? (pos >= MEB_POS_DSTB_LO) :
        (second_d && pos <= MEB_POS_DSTB_END);
    wire nxt_rd_n = !(dstb && !xr_ff.write);
    wire nxt_wr_n = !(dstb && xr_ff.write);
    // port 0: address first, then write data or released
    wire nxt_p0_oe = (nxt_fslot && addr_ph) || (first_d && addr_ph) ||
        (nxt_dslot && xr_ff.write);
    // address held through the latch strobe fall
    wire [7:0] nxt_p0_o = (first_d && addr_ph) ? xr_ff.addr[7:0] :
        nxt_dslot ? xr_ff.wdata : fetch_addr[7:0];
    // port 2: high byte or latch content
    wire [7:0] nxt_p2_o = (nxt_dslot && xr_ff.wide) ? xr_ff.addr[15:8] :
        nxt_fslot ? fetch_addr[15:8] : p2_latch;
    wire nxt_busy = (pend_ff || accept || nxt_st != MEB_ST_NORM) &&
        !(wrap && st_ff == MEB_ST_MX2 && !accept && !pend_ff);
    wire program_store_strobe_n_rise = program_store_strobe_n && !program_store_strobe_n_d_ff;
    wire rd_rise = rd_n && !rd_d_ff;
    wire wr_rise = wr_n && !wr_d_ff;

    always_comb begin
        nxt_st = st_ff;
        if (wrap) begin
            case (st_ff)
                MEB_ST_NORM: nxt_st = (pend_ff || accept) ? MEB_ST_MX1 : MEB_ST_NORM;
                MEB_ST_MX1: nxt_st = MEB_ST_MX2;
                MEB_ST_MX2: nxt_st = MEB_ST_NORM;
                default: nxt_st = MEB_ST_NORM;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= MEB_ST_NORM;
            pend_ff <= 1'b0;
            xr_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            pend_ff <= (pend_ff || accept) && !(wrap && st_ff == MEB_ST_NORM);
            if (accept) begin
                xr_ff <= xm_cmd;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ale <= 1'b0;
            program_store_strobe_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            p0_o <= MEB_BYTE_RST;
            p0_oe <= 1'b0;
            p2_o <= MEB_BYTE_RST;
            dslot_ff <= 1'b0;
            fslot_ff <= 1'b0;
            mc_start <= 1'b0;
            xm_busy <= 1'b0;
        end else begin
            ale <= nxt_ale;
            program_store_strobe_n <= nxt_program_store_strobe_n_n;
            rd_n <= nxt_rd_n;
            wr_n <= nxt_wr_n;
            p0_o <= nxt_p0_o;
            p0_oe <= nxt_p0_oe;
            p2_o <= nxt_p2_o;
            dslot_ff <= nxt_dslot;
            fslot_ff <= nxt_fslot;
            mc_start <= (nxt_idx == MEB_IDX_RST);
            xm_busy <= nxt_busy;
        end
    end

    // pin synchroniser; capture the byte present at the strobe rise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p0_s1_ff <= MEB_BYTE_RST;
            p0_s2_ff <= MEB_BYTE_RST;
            program_store_strobe_n_d_ff <= 1'b1;
            rd_d_ff <= 1'b1;
            wr_d_ff <= 1'b1;
            cap_f_ff <= 1'b0;
            cap_r_ff <= 1'b0;
            fetch_data <= MEB_BYTE_RST;
            fetch_valid <= 1'b0;
            xm_rdata <= MEB_BYTE_RST;
            xm_done <= 1'b0;
        end else begin
            p0_s1_ff <= p0_i;
            p0_s2_ff <= p0_s1_ff;
            program_store_strobe_n_d_ff <= program_store_strobe_n;
            rd_d_ff <= rd_n;
            wr_d_ff <= wr_n;
            cap_f_ff <= program_store_strobe_n_rise;
            cap_r_ff <= rd_rise;
            fetch_valid <= cap_f_ff;
            if (cap_f_ff) begin
                fetch_data <= p0_s2_ff;
            end
            if (cap_r_ff) begin
                xm_rdata <= p0_s2_ff;
            end
            xm_done <= cap_r_ff || wr_rise;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_ale_rate;
        $rose(ale) && st_ff == MEB_ST_NORM |-> ##6 $rose(ale);
    endproperty
    a_ale_rate: assert property (p_ale_rate) else $error("latch strobe rate off");

    property p_ale_pos;
        $rose(ale) |-> (idx_ff == 4'h1 || idx_ff == 4'h7) ##1 ale ##1 !ale;
    endproperty
    a_ale_pos: assert property (p_ale_pos) else $error("latch strobe misplaced");

    property p_program_store_strobe_n_len;
        $fell(program_store_strobe_n) |-> !program_store_strobe_n[*2]
            ##1 program_store_strobe_n[*4];
    endproperty
    a_program_store_strobe_n_len: assert property (p_program_store_strobe_n_len) else $error("fetch strobe length");

    property p_no_program_store_strobe_n_data;
        dslot_ff |-> program_store_strobe_n && !fslot_ff;
    endproperty
    a_no_program_store_strobe_n_data: assert property (p_no_program_store_strobe_n_data) else $error("fetch in data slot");

    property p_suppress;
        st_ff == MEB_ST_MX2 && idx_ff < 4'h6 |-> !ale;
    endproperty
    a_suppress: assert property (p_suppress) else $error("latch strobe not removed");

    property p_rd_len;
        $fell(rd_n) |-> !rd_n[*6] ##1 rd_n;
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("read strobe length");

    property p_wr_data;
        $fell(wr_n) |-> $past(p0_oe) && p0_oe && $stable(p0_o) ##0 (p0_oe [*7]);
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data not held");

    property p_rd_release;
        !rd_n |-> !p0_oe;
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("port 0 driven on read");

    property p_ale_addr;
        $fell(ale) && (fslot_ff || dslot_ff) |-> p0_oe && $stable(p0_o);
    endproperty
    a_ale_addr: assert property (p_ale_addr) else $error("address not held");

    property p_p2_wide;
        dslot_ff && xr_ff.wide |-> p2_o == xr_ff.addr[15:8];
    endproperty
    a_p2_wide: assert property (p_p2_wide) else $error("port 2 high byte");

    property p_p2_latch;
        (dslot_ff && !xr_ff.wide) || (!dslot_ff && !fslot_ff)
            |-> p2_o == $past(p2_latch);
    endproperty
    a_p2_latch: assert property (p_p2_latch) else $error("port 2 latch lost");

    property p_program_store_strobe_n_fetch;
        !program_store_strobe_n |-> fslot_ff && rd_n && wr_n;
    endproperty
    a_program_store_strobe_n_fetch: assert property (p_program_store_strobe_n_fetch) else $error("fetch strobe outside fetch");

    property p_p2_fetch;
        fslot_ff |-> p2_o == $past(fetch_addr[15:8]);
    endproperty
    a_p2_fetch: assert property (p_p2_fetch) else $error("fetch high byte missing");

    property p_p0_addr;
        $fell(ale) && dslot_ff |-> p0_oe && p0_o == xr_ff.addr[7:0];
    endproperty
    a_p0_addr: assert property (p_p0_addr) else $error("data low address wrong");

    property p_wr_value;
        !wr_n |-> p0_oe && p0_o == xr_ff.wdata;
    endproperty
    a_wr_value: assert property (p_wr_value) else $error("write data wrong");

    property p_dslot_len;
        $rose(dslot_ff) |-> dslot_ff [*6] ##1 dslot_ff [*6] ##1 !dslot_ff;
    endproperty
    a_dslot_len: assert property (p_dslot_len) else $error("data slot length");

    property p_ale_slot_a;
        idx_ff == 4'h1 && st_ff != MEB_ST_MX2 |-> $rose(ale);
    endproperty
    a_ale_slot_a: assert property (p_ale_slot_a) else $error("first latch strobe missing");

    property p_ale_slot_b;
        idx_ff == 4'h7 |-> $rose(ale);
    endproperty
    a_ale_slot_b: assert property (p_ale_slot_b) else $error("second latch strobe missing");

    c_wrap_take: cover property (accept && wrap);
    c_read: cover property ($rose(xm_done) && !xr_ff.write);
    c_write: cover property ($fell(wr_n) && xr_ff.wide);
    c_fetch: cover property (fetch_valid && ext_fetch_en);
    c_narrow: cover property ($fell(rd_n) && !xr_ff.wide);

endmodule

// ==== tb/meb_ext_mem.sv ====
// partner model: program memory plus data memory with on-chip address latch
// assumes pins come straight from meb_bus_ctrl; port 0 has no pull-ups
module meb_ext_mem (
    // strobes and address from the device
    input wire logic ale,
    input wire logic program_store_strobe_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] p0_o,
    input wire logic p0_oe,
    input wire logic [7:0] p2_o,
    // port 0 level back to the device
    output logic [7:0] p0_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] lo_ff;
    logic [7:0] last = 8'h00;
    logic [7:0] ram [65536];
    wire [15:0] addr = {p2_o, lo_ff};
    wire code_on = !program_store_strobe_n;
    wire [7:0] val = code_on ? (addr[7:0] ^ addr[15:8] ^ 8'h5a) : ram[addr];
    // unwritten cells read as the inverted low address
    initial for (int i = 0; i < 65536; i++) ram[i] = ~i[7:0];
    always @(negedge ale) lo_ff = p0_o;
    always @(posedge wr_n) ram[addr] = p0_o;
    always @* if (code_on || !rd_n) last = val;
    // released bus shows a changed level, not the old byte
    assign p0_i = p0_oe ? p0_o : (code_on || !rd_n) ? val : ~last;
endmodule

// ==== tb/muxed_external_memory_bus_tb.sv ====
// self-checking bench of meb_bus_ctrl against the external memory model
// assumes meb_pkg and meb_ext_mem are compiled first
module muxed_external_memory_bus_tb
    import meb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        meb_xreq_t cmd;
        logic [7:0] p2l;
        logic [7:0] exp;
    } meb_row_t;
    meb_row_t rows [8] = '{
        '{'{1'b1, 1'b1, 16'h1234, 8'ha5}, 8'h00, 8'h00},
        '{'{1'b1, 1'b0, 16'h0056, 8'h3c}, 8'h77, 8'h00},
        '{'{1'b0, 1'b1, 16'h1234, 8'h00}, 8'h00, 8'ha5},
        '{'{1'b0, 1'b0, 16'h0056, 8'h00}, 8'h77, 8'h3c},
        '{'{1'b0, 1'b1, 16'h7756, 8'h00}, 8'h00, 8'h3c},
        '{'{1'b0, 1'b0, 16'h0034, 8'h00}, 8'h12, 8'ha5},
        '{'{1'b1, 1'b1, 16'hffff, 8'h96}, 8'h00, 8'h00},
        '{'{1'b0, 1'b0, 16'h00ff, 8'h00}, 8'hff, 8'h96}
    };
    logic [15:0] faddr [2] = '{16'h8123, 16'hfe01};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ext_fetch_en = 1'b0;
    logic [15:0] fetch_addr = 16'h0000;
    logic xm_req = 1'b0;
    meb_xreq_t xm_cmd = '0;
    meb_xreq_t cur = '0;
    logic [7:0] p2_latch = 8'h00;
    logic [7:0] fetch_data, xm_rdata, p0_o, p0_i, p2_o;
    logic fetch_valid, xm_busy, xm_done, mc_start, ale, program_store_strobe_n, rd_n, wr_n, p0_oe;
    logic chk_f = 1'b0, ale_q = 1'b0, wr_q = 1'b1, mc_q = 1'b0, mc_seen = 1'b0, busy_seen = 1'b0;
    int mismatches = 0, cmp_count = 0, n_ale = 0, n_ps = 0, n_pw = 0, n_st = 0, n_cy = 0;
    wire [7:0] p2x = cur.wide ? cur.addr[15:8] : p2_latch;
    always #12.5 clk = ~clk;
    meb_bus_ctrl uut (.clk, .rstn, .ext_fetch_en, .fetch_addr, .fetch_data, .fetch_valid,
        .xm_req, .xm_cmd, .xm_busy, .xm_rdata, .xm_done, .p2_latch, .mc_start, .ale,
        .program_store_strobe_n, .rd_n, .wr_n, .p0_o, .p0_oe, .p0_i, .p2_o);
    meb_ext_mem mem (.ale, .program_store_strobe_n, .rd_n, .wr_n, .p0_o, .p0_oe, .p2_o, .p0_i);
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // leaves us just after the edge into the last index of a machine cycle
    task automatic to_edge;
        do step(1); while (mc_start !== 1'b1);
        step(11);
    endtask
    // a ghost request is raised while busy and must be ignored
    task automatic move(input meb_xreq_t c, input logic ghost);
        int n;
        n = 0;
        while (xm_busy !== 1'b0) step(1);
        cur = c;
        xm_cmd = c;
        xm_req = 1'b1;
        step(1);
        xm_req = 1'b0;
        chk("busy after take", 8'h1, {7'h0, xm_busy});
        step(1);
        xm_req = ghost;
        xm_cmd = ~c;
        step(3);
        xm_req = 1'b0;
        while (xm_done !== 1'b1 && n < 60) begin
            step(1);
            n++;
        end
        chk("move done", 8'h1, {7'h0, xm_done});
    endtask
    always @(posedge clk) begin
        #3;
        if (rstn === 1'b1) begin
            if (!program_store_strobe_n) chk("strobe overlap", 8'h1, {7'h0, rd_n & wr_n});
            if (!rd_n || !wr_n) chk("p2 pins", p2x, p2_o);
            if (!wr_n || !wr_q) chk("write data", cur.wdata, p0_oe ? p0_o : ~cur.wdata);
            if (!rd_n) chk("read release", 8'h0, {7'h0, p0_oe});
            if (fetch_valid && chk_f) chk("fetch byte", fetch_addr[7:0] ^ fetch_addr[15:8] ^ 8'h5a, fetch_data);
            if (!rd_n || !wr_n) n_st++;
            else if (n_st != 0) begin
                chk("data strobe width", 8'h6, n_st[7:0]);
                n_st = 0;
            end
            if (!program_store_strobe_n) begin
                n_ps += (n_pw == 0);
                n_pw++;
            end else if (n_pw != 0) begin
                chk("fetch strobe width", 8'h2, n_pw[7:0]);
                n_pw = 0;
            end
            n_ale += (ale && !ale_q);
            n_cy++;
            busy_seen |= xm_busy;
            if (mc_q && !xm_busy && mc_seen) chk("ale position", 8'h1, {7'h0, ale});
            if (mc_start) begin
                if (mc_seen) chk("cycle length", 8'd12, n_cy[7:0]);
                if (mc_seen && !busy_seen) chk("ale per cycle", 8'h2, n_ale[7:0]);
                if (busy_seen) chk("ale in move", 8'h1, {7'h0, n_ale inside {1, 2}});
                if (chk_f && !busy_seen) chk("fetch strobes", 8'h2, n_ps[7:0]);
                mc_seen = 1'b1;
                busy_seen = 1'b0;
                n_cy = 0;
                n_ale = 0;
                n_ps = 0;
            end
            ale_q = ale;
            wr_q = wr_n;
            mc_q = mc_start;
        end
    end
    initial begin
        int n;
        step(10);
        chk("reset pins", 8'h06, {4'h0, ale, program_store_strobe_n, rd_n & wr_n, p0_oe});
        step(10);
        rstn = 1'b1;
        $display("reset test done");
        foreach (faddr[k]) begin
            to_edge();
            chk_f = 1'b0;
            fetch_addr = faddr[k];
            ext_fetch_en = 1'b1;
            step(12);
            chk_f = 1'b1;
            step(36);
            $display("fetch test %0d done", k);
        end
        foreach (rows[k]) begin
            p2_latch = rows[k].p2l;
            move(rows[k].cmd, 1'b0);
            if (!rows[k].cmd.write) chk("read byte", rows[k].exp, xm_rdata);
            $display("row %0d done", k);
        end
        p2_latch = 8'h77;
        move('{1'b0, 1'b1, 16'h1234, 8'h00}, 1'b1);
        chk("read byte", 8'ha5, xm_rdata);
        move('{1'b0, 1'b0, 16'h00cb, 8'h00}, 1'b0);
        chk("ignored request", 8'h34, xm_rdata);
        $display("busy request test done");
        to_edge();
        chk_f = 1'b0;
        ext_fetch_en = 1'b0;
        n = 0;
        repeat (24) begin
            step(1);
            n += (!program_store_strobe_n || p0_oe || p2_o !== p2_latch);
        end
        chk("fetch off activity", 8'h0, n[7:0]);
        $display("fetch off test done");
        end_of_test();
    end
    initial begin
        #(25 * 20000);
        mismatches++;
        end_of_test();
    end
endmodule
